// [etfc_pkg.sv]
// package: register map, field layout, reset values and timing counts for the tx/flow control block
package etfc_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] TX_CTRL_OFS = 12'h000;
   localparam logic [11:0] PAUSE_CTRL_OFS = 12'h004;
   localparam logic [11:0] AUTO_PAUSE_OFS = 12'h008;
   localparam logic [11:0] OFFLOAD_OFS = 12'h00c;
   localparam logic [11:0] STATUS_OFS = 12'h010;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TX_ON_BIT = 0;
   localparam int STOP_TX_BIT = 1;
   localparam int FLUSH_BIT = 2;
   localparam int MAC_MAC_TRANSMIT_ENABLE_BIT = 3;
   localparam int PC_EN_BIT = 0;
   localparam int PC_FULLDUP_BIT = 1;
   localparam int PC_TIME_LSB = 16;
   localparam int AP_HI_LSB = 0;
   localparam int AP_LO_LSB = 8;
   localparam int AP_DUR_LSB = 16;
   localparam int AP_ANY_BIT = 24;
   localparam int AP_ADDR_BIT = 25;
   localparam int AP_MULT_BIT = 26;
   localparam int AP_BRD_BIT = 27;
   localparam int OFF_EN_BIT = 0;
   // ------------------------------------------------------------
   // reset values and constants
   // ------------------------------------------------------------
   localparam logic [31:0] TX_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PAUSE_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] AUTO_PAUSE_RST = 32'h0000_0000;
   localparam logic [7:0] THR_ALL_ONES = 8'hff;
   localparam logic [7:0] THR_ALL_ZERO = 8'h00;
   localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
   // ------------------------------------------------------------
   // timing: slot time 512 bit times, ipg, clock period
   // ------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int SLOT_BITS = 512;
   localparam int IPG10_PS = 9600000;
   localparam int IPG100_PS = 960000;
   // one bit time at 100 Mbps is 10 ns, at 10 Mbps 100 ns
   localparam int SLOT_CYC_100 = (SLOT_BITS * 10) / CLK_NS;
   localparam int SLOT_CYC_10 = (SLOT_BITS * 100) / CLK_NS;
   localparam int IPG_CYC_100 = (IPG100_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
   localparam int IPG_CYC_10 = (IPG10_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
   typedef enum logic [1:0]
   {
      ETFC_GNT_NONE = 2'b00,
      ETFC_GNT_HOLD = 2'b01
   } etfc_gnt_st_t;
endpackage : etfc_pkg

// [etfc_arb_if.sv]
// interface: requests and grants between the top and the fifo arbiter
`timescale 1ns/10ps
interface etfc_arb_if;
   logic [3:0] req;
   logic [3:0] done;
   logic [3:0] gnt;
   modport ctl (output req, output done, input gnt);
   modport arb (input req, input done, output gnt);
endinterface : etfc_arb_if

// [etfc_arb.sv]
// module: strict priority fifo access arbiter with grant hold
`timescale 1ns/10ps
module etfc_arb
   import etfc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   etfc_arb_if.arb bus
);
   etfc_gnt_st_t st;
   logic [3:0] gnt_q;

   // lowest index has highest priority
   function automatic logic [3:0] etfc_pick(input logic [3:0] r);
      logic [3:0] g;
      g = 4'h0;
      if (r[0])
         g = 4'h1;
      else if (r[1])
         g = 4'h2;
      else if (r[2])
         g = 4'h4;
      else if (r[3])
         g = 4'h8;
      return g;
   endfunction : etfc_pick

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= ETFC_GNT_NONE;
         gnt_q <= 4'h0;
      end
      else
      begin
         case (st)
            ETFC_GNT_NONE:
            begin
               if (|bus.req)
               begin
                  gnt_q <= etfc_pick(bus.req);
                  st <= ETFC_GNT_HOLD;
               end
            end
            ETFC_GNT_HOLD:
            begin
               // grant stays until its own transfer completes
               if (|(gnt_q & bus.done))
               begin
                  gnt_q <= 4'h0;
                  st <= ETFC_GNT_NONE;
               end
            end
            default:
            begin
               st <= ETFC_GNT_NONE;
               gnt_q <= 4'h0;
            end
         endcase
      end
   end
   assign bus.gnt = gnt_q;

   onehot_gnt_a: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(bus.gnt)) else $error("more than one grant");
   prio_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st == ETFC_GNT_NONE && bus.req[0]) |=> bus.gnt == 4'h1)
      else $error("bulk-out not granted first");
   grant_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|bus.gnt && !(|(bus.gnt & bus.done))) |=> bus.gnt == $past(bus.gnt))
      else $error("grant dropped early");
endmodule : etfc_arb

// [etfc_top.sv]
// module: tx control, fifo flush, stop/start and flow control with apb registers
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - flush returns both tx fifo pointers to reset values.
// - flush bit clears itself when the flush finishes.
// - stop waits for current frame status, clears stop and on, pulses halt.
// - without flush, restart resumes from pending fifo data.
// - fifo grants go bulk-out, bulk-in, mac receive, mac transmit.
// - mac side requesters tolerate wait states using local buffering.
// - back-to-back minimum frames with 9.6 us / 0.96 us gap.
// - no pause or backpressure unless flow control enable set.
// - received pause blocks data frames for parameter times 512 bit times.
// - pause takes effect after current transmission; control frames passed on.
// - rx level at high threshold sends pause with programmed time.
// - rx level below low threshold sends pause time zero.
// - next pause only after level falls below low then rises past high.
// - half duplex jams only at start of new received frames after tx ends.
// - high threshold starts backpressure timer; qualifier bits select frames.
// - timer expiry accepts one frame; restart if level still above low.
// - level below low resets timer at once; off until high again.
// - low 0xff and high 0x00 means high threshold always exceeded.
module etfc_top
   import etfc_pkg::*;
#(
   parameter int FIFO_AW = 9,
   parameter int SLOT_CYC = SLOT_CYC_100,
   parameter int IPG_CYC = IPG_CYC_100
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic first_segment_flag,
   input wire logic csum_request_bit,
   output logic csum_generate,
   input wire logic tx_fifo_wr,
   input wire logic tx_fifo_rd,
   output logic [FIFO_AW-1:0] tx_wr_ptr,
   output logic [FIFO_AW-1:0] tx_rd_ptr,
   output logic tx_data_pending,
   input wire logic tx_busy,
   input wire logic tx_status_valid,
   output logic tx_frame_start_ok,
   output logic transmitter_halted_pulse,
   input wire logic [3:0] fifo_req,
   input wire logic [3:0] fifo_done,
   output logic [3:0] fifo_gnt,
   input wire logic pause_rx_valid,
   input wire logic [15:0] pause_rx_time,
   output logic pause_active,
   input wire logic [7:0] rx_level,
   output logic pause_tx_req,
   output logic [15:0] pause_tx_time,
   input wire logic pause_tx_done,
   input wire logic rx_frame_start,
   input wire logic rx_frame_end,
   input wire logic rx_addr_match,
   input wire logic rx_multicast,
   input wire logic rx_broadcast,
   output logic jam_out
);
   logic [31:0] tx_ctrl;
   logic [31:0] pause_ctrl;
   logic [31:0] auto_pause;
   logic tx_ctrl_offload;
   logic wr_en;
   logic rd_en;
   logic tx_fifo_nonempty;
   logic stop_wait;
   logic [31:0] slot_cnt;
   logic [15:0] pause_quanta;
   logic pending_pause_valid;
   logic [15:0] pending_pause;
   logic [7:0] hi_thr;
   logic [7:0] lo_thr;
   logic fc_en;
   logic full_dup;
   logic hi_reached;
   logic below_lo;
   logic armed;
   logic [7:0] bp_timer;
   logic bp_on;
   logic accept_one;
   logic qual_hit;
   logic [15:0] ipg_cnt;
   etfc_arb_if arb_bus ();

   // ------------------------------------------------------------
   // apb slave: zero wait states, unmapped addresses read zero and error
   // ------------------------------------------------------------
   function automatic logic etfc_mapped(input logic [11:0] a);
      return a == TX_CTRL_OFS || a == PAUSE_CTRL_OFS || a == AUTO_PAUSE_OFS
         || a == OFFLOAD_OFS || a == STATUS_OFS;
   endfunction : etfc_mapped

   assign pready = 1'b1;
   assign pslverr = psel && penable && !etfc_mapped(paddr);
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         case (paddr)
            TX_CTRL_OFS: prdata <= tx_ctrl;
            PAUSE_CTRL_OFS: prdata <= pause_ctrl;
            AUTO_PAUSE_OFS: prdata <= auto_pause;
            OFFLOAD_OFS: prdata <= {31'h0, tx_ctrl_offload};
            STATUS_OFS: prdata <= {27'h0, jam_out, bp_on, pause_active,
               stop_wait, tx_fifo_nonempty};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pause_ctrl <= PAUSE_CTRL_RST;
         auto_pause <= AUTO_PAUSE_RST;
         tx_ctrl_offload <= 1'b0;
      end
      else if (wr_en)
      begin
         if (paddr == PAUSE_CTRL_OFS)
            pause_ctrl <= pwdata;
         if (paddr == AUTO_PAUSE_OFS)
            auto_pause <= pwdata;
         if (paddr == OFFLOAD_OFS)
            tx_ctrl_offload <= pwdata[OFF_EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // transmit control: stop, restart, flush
   // ------------------------------------------------------------
   // the status return clears stop and on; a software write in the same
   // cycle is lost for those two bits, flush completes in one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_ctrl <= TX_CTRL_RST;
      else
      begin
         if (wr_en && paddr == TX_CTRL_OFS)
            tx_ctrl <= {28'h0, pwdata[3:0]};
         if (tx_ctrl[FLUSH_BIT])
            tx_ctrl[FLUSH_BIT] <= 1'b0;
         if (stop_wait && tx_status_valid)
         begin
            tx_ctrl[STOP_TX_BIT] <= 1'b0;
            tx_ctrl[TX_ON_BIT] <= 1'b0;
         end
      end
   end

   // the stop stays pending until the status of the frame on the wire returns
   assign stop_wait = tx_ctrl[STOP_TX_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         transmitter_halted_pulse <= 1'b0;
      else
         transmitter_halted_pulse <= stop_wait && tx_status_valid;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_wr_ptr <= '0;
         tx_rd_ptr <= '0;
      end
      else if (tx_ctrl[FLUSH_BIT])
      begin
         tx_wr_ptr <= '0;
         tx_rd_ptr <= '0;
      end
      else
      begin
         if (tx_fifo_wr)
            tx_wr_ptr <= tx_wr_ptr + 1'b1;
         if (tx_fifo_rd && tx_fifo_nonempty)
            tx_rd_ptr <= tx_rd_ptr + 1'b1;
      end
   end
   assign tx_fifo_nonempty = tx_wr_ptr != tx_rd_ptr;
   // pointers survive a stop, so restart resumes on what is left
   assign tx_data_pending = tx_fifo_nonempty;

   // checksum gate
   assign csum_generate = first_segment_flag && csum_request_bit && tx_ctrl_offload;

   // ------------------------------------------------------------
   // fifo arbitration
   // ------------------------------------------------------------
   assign arb_bus.req = fifo_req;
   assign arb_bus.done = fifo_done;
   assign fifo_gnt = arb_bus.gnt;
   etfc_arb u_arb (.pclk(pclk), .presetn(presetn), .bus(arb_bus));

   // ------------------------------------------------------------
   // full duplex pause reception and generation
   // ------------------------------------------------------------
   assign fc_en = pause_ctrl[PC_EN_BIT];
   assign full_dup = pause_ctrl[PC_FULLDUP_BIT];
   assign hi_thr = auto_pause[AP_HI_LSB +: 8];
   assign lo_thr = auto_pause[AP_LO_LSB +: 8];
   assign hi_reached = (lo_thr == THR_ALL_ONES && hi_thr == THR_ALL_ZERO)
      || rx_level >= hi_thr;
   assign below_lo = !(lo_thr == THR_ALL_ONES && hi_thr == THR_ALL_ZERO)
      && rx_level < lo_thr;

   // the pause is latched while a frame is on the wire and loaded after it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending_pause_valid <= 1'b0;
         pending_pause <= 16'h0000;
         pause_quanta <= 16'h0000;
         slot_cnt <= '0;
      end
      else
      begin
         if (pause_rx_valid && fc_en)
         begin
            pending_pause_valid <= 1'b1;
            pending_pause <= pause_rx_time;
         end
         else if (pending_pause_valid && !tx_busy)
         begin
            pending_pause_valid <= 1'b0;
            pause_quanta <= pending_pause;
            slot_cnt <= '0;
         end
         else if (pause_quanta != 16'h0000)
         begin
            if (slot_cnt == 32'(SLOT_CYC - 1))
            begin
               slot_cnt <= '0;
               pause_quanta <= pause_quanta - 16'h0001;
            end
            else
               slot_cnt <= slot_cnt + 32'd1;
         end
      end
   end
   assign pause_active = pause_quanta != 16'h0000;

   // armed means a below-low crossing has been seen since the last pause-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         armed <= 1'b1;
         pause_tx_req <= 1'b0;
         pause_tx_time <= 16'h0000;
      end
      else if (pause_tx_req)
      begin
         if (pause_tx_done)
            pause_tx_req <= 1'b0;
      end
      else if (fc_en && full_dup)
      begin
         if (armed && hi_reached)
         begin
            armed <= 1'b0;
            pause_tx_req <= 1'b1;
            pause_tx_time <= pause_ctrl[PC_TIME_LSB +: 16];
         end
         else if (!armed && below_lo)
         begin
            armed <= 1'b1;
            pause_tx_req <= 1'b1;
            pause_tx_time <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // half duplex backpressure
   // ------------------------------------------------------------
   assign qual_hit = auto_pause[AP_ANY_BIT]
      || (auto_pause[AP_ADDR_BIT] && rx_addr_match)
      || (auto_pause[AP_MULT_BIT] && rx_multicast)
      || (auto_pause[AP_BRD_BIT] && rx_broadcast);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bp_on <= 1'b0;
         bp_timer <= 8'h00;
         accept_one <= 1'b0;
      end
      else if (!fc_en || full_dup || below_lo)
      begin
         bp_on <= 1'b0;
         bp_timer <= 8'h00;
         accept_one <= 1'b0;
      end
      else if (accept_one)
      begin
         if (rx_frame_end)
         begin
            // not below low here, so the timer runs again
            accept_one <= 1'b0;
            bp_on <= 1'b1;
            bp_timer <= 8'h00;
         end
      end
      else if (bp_on)
      begin
         if (bp_timer == auto_pause[AP_DUR_LSB +: 8])
         begin
            bp_on <= 1'b0;
            accept_one <= 1'b1;
         end
         else
            bp_timer <= bp_timer + 8'h01;
      end
      else if (hi_reached)
         bp_on <= 1'b1;
   end

   // jam starts only with a new frame and after our own frame ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         jam_out <= 1'b0;
      else if (!bp_on || !fc_en || full_dup)
         jam_out <= 1'b0;
      else if (rx_frame_start && !tx_busy && qual_hit)
         jam_out <= 1'b1;
      else if (rx_frame_end)
         jam_out <= 1'b0;
   end

   // ------------------------------------------------------------
   // interpacket gap and frame start permission
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ipg_cnt <= 16'h0000;
      else if (tx_busy)
         ipg_cnt <= 16'(IPG_CYC);
      else if (ipg_cnt != 16'h0000)
         ipg_cnt <= ipg_cnt - 16'h0001;
   end
   assign tx_frame_start_ok = tx_ctrl[TX_ON_BIT] && tx_ctrl[MAC_MAC_TRANSMIT_ENABLE_BIT]
      && !tx_ctrl[STOP_TX_BIT] && !pause_active && !pending_pause_valid
      && ipg_cnt == 16'h0000 && tx_fifo_nonempty;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   csum_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      csum_generate |-> first_segment_flag && csum_request_bit && tx_ctrl_offload)
      else $error("checksum without enables");
   flush_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_ctrl[FLUSH_BIT] |=> tx_wr_ptr == '0 && tx_rd_ptr == '0)
      else $error("flush left pointers");
   flush_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_ctrl[FLUSH_BIT] |=> !tx_ctrl[FLUSH_BIT] || $past(wr_en))
      else $error("flush bit stuck");
   stop_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      (stop_wait && tx_status_valid) |=> transmitter_halted_pulse
      && !tx_ctrl[TX_ON_BIT] ##1 !transmitter_halted_pulse)
      else $error("stop not completed");
   fc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !fc_en |=> !bp_on && !jam_out) else $error("backpressure while disabled");
   pause_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      pause_active |-> !tx_frame_start_ok) else $error("start during pause");
   pause_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pending_pause_valid && tx_busy && !pause_rx_valid) |=> pending_pause_valid)
      else $error("pause took effect mid frame");
   pause_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(pause_tx_req) && armed) |-> pause_tx_time == 16'h0000)
      else $error("resume pause not zero");
   low_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fc_en && below_lo) |=> bp_timer == 8'h00 && !bp_on)
      else $error("timer not reset below low");
   ipg_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(tx_busy) |-> !tx_frame_start_ok) else $error("gap skipped");
   stop_seen_c: cover property (@(posedge pclk) transmitter_halted_pulse);
   pause_sent_c: cover property (@(posedge pclk) pause_tx_req && pause_tx_done);
   jam_seen_c: cover property (@(posedge pclk) $rose(jam_out));
   accept_c: cover property (@(posedge pclk) $rose(accept_one));
endmodule : etfc_top

// [etfc_far_model.sv]
// far-side model: fifo transfer completion and pause frame send completion
`timescale 1ns/10ps
module etfc_far_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [3:0] fifo_gnt,
   output logic [3:0] fifo_done,
   input wire logic pause_tx_req,
   output logic pause_tx_done
);
   // ------------------------------------------------------------
   // completion handshakes
   // ------------------------------------------------------------
   logic [2:0] wait_cnt;
   logic sent;
   logic pause_sent;
   // slow mode keeps a grant busy for a few cycles so its hold is visible
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_cnt <= 3'h0;
         sent <= 1'b0;
         fifo_done <= 4'h0;
      end
      else
      begin
         fifo_done <= 4'h0;
         if (fifo_gnt == 4'h0)
         begin
            sent <= 1'b0;
            wait_cnt <= 3'h0;
         end
         else if (!sent && wait_cnt >= (slow ? 3'h3 : 3'h0))
         begin
            fifo_done <= fifo_gnt;
            sent <= 1'b1;
         end
         else
            wait_cnt <= wait_cnt + 3'h1;
      end
   end
   // one completion per request level, so a stuck request is not acked twice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pause_sent <= 1'b0;
         pause_tx_done <= 1'b0;
      end
      else
      begin
         pause_tx_done <= pause_tx_req && !pause_sent;
         pause_sent <= pause_tx_req;
      end
   end
endmodule : etfc_far_model

// [etfc_top_tb.sv]
// testbench: register access, tx stop and flush, arbiter, pause and backpressure
`timescale 1ns/10ps
module etfc_top_tb;
   import etfc_pkg::*;
   localparam int SLOT_T = 8;
   localparam int IPG_T = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic first_segment_flag, csum_request_bit, csum_generate, tx_fifo_wr, tx_fifo_rd;
   logic [8:0] tx_wr_ptr, tx_rd_ptr;
   logic tx_data_pending, tx_busy, tx_status_valid, tx_frame_start_ok;
   logic transmitter_halted_pulse, pause_rx_valid, pause_active, pause_tx_req;
   logic [3:0] fifo_req, fifo_done, fifo_gnt;
   logic [15:0] pause_rx_time, pause_tx_time;
   logic [7:0] rx_level;
   logic pause_tx_done, rx_frame_start, rx_frame_end, rx_addr_match, rx_multicast;
   logic rx_broadcast, jam_out;
   int failures = 0;
   int total_checks = 0;
   int i, n;
   etfc_top #(.FIFO_AW(9), .SLOT_CYC(SLOT_T), .IPG_CYC(IPG_T)) i_dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .first_segment_flag, .csum_request_bit, .csum_generate, .tx_fifo_wr, .tx_fifo_rd,
      .tx_wr_ptr, .tx_rd_ptr, .tx_data_pending, .tx_busy, .tx_status_valid,
      .tx_frame_start_ok, .transmitter_halted_pulse, .fifo_req, .fifo_done, .fifo_gnt,
      .pause_rx_valid, .pause_rx_time, .pause_active, .rx_level, .pause_tx_req,
      .pause_tx_time, .pause_tx_done, .rx_frame_start, .rx_frame_end, .rx_addr_match,
      .rx_multicast, .rx_broadcast, .jam_out);
   etfc_far_model i_far (.pclk, .presetn, .slow, .fifo_gnt, .fifo_done, .pause_tx_req,
      .pause_tx_done);
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (k == 16)
         failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask : rd
   task automatic status_back();
      @(posedge pclk);
      tx_status_valid <= 1'b1;
      @(posedge pclk);
      tx_status_valid <= 1'b0;
   endtask : status_back
   task automatic frame_start();
      @(posedge pclk);
      rx_frame_start <= 1'b1;
      @(posedge pclk);
      rx_frame_start <= 1'b0;
      @(negedge pclk);
   endtask : frame_start
   // ------------------------------------------------------------
   // clock, watchdog and scenarios
   // ------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      #2000000;
      failures++;
      test_done();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, first_segment_flag, csum_request_bit} = '0;
      {tx_fifo_wr, tx_fifo_rd, tx_busy, tx_status_valid, fifo_req, pause_rx_valid} = '0;
      {pause_rx_time, rx_level, rx_frame_start, rx_frame_end, rx_addr_match} = '0;
      {rx_multicast, rx_broadcast} = '0;
      slow = 1'b1;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(TX_CTRL_OFS, TX_CTRL_RST);
      rd(PAUSE_CTRL_OFS, PAUSE_CTRL_RST);
      rd(12'h020, 32'h0);
      chk(e, 1'b1);
      for (i = 0; i < 8; i++)
      begin
         apb(1'b1, OFFLOAD_OFS, {31'h0, i[2]});
         @(posedge pclk);
         first_segment_flag <= i[1];
         csum_request_bit <= i[0];
         @(negedge pclk);
         chk(csum_generate, &i[2:0]);
      end
      apb(1'b1, TX_CTRL_OFS, 32'h9);
      @(posedge pclk);
      tx_fifo_wr <= 1'b1;
      tx_busy <= 1'b1;
      repeat (3) @(posedge pclk);
      tx_fifo_wr <= 1'b0;
      apb(1'b1, TX_CTRL_OFS, 32'hb);
      chk(tx_wr_ptr, 3);
      rd(TX_CTRL_OFS, 32'hb);
      tx_busy <= 1'b0;
      status_back();
      n = 0;
      repeat (6)
      begin
         @(negedge pclk);
         n += transmitter_halted_pulse;
      end
      chk(n, 1);
      rd(TX_CTRL_OFS, 32'h8);
      chk(tx_data_pending, 1'b1);
      apb(1'b1, TX_CTRL_OFS, 32'h9);
      repeat (IPG_T + 2) @(negedge pclk);
      chk(tx_frame_start_ok, 1'b1);
      apb(1'b1, TX_CTRL_OFS, 32'hb);
      status_back();
      rd(TX_CTRL_OFS, 32'h8);
      apb(1'b1, TX_CTRL_OFS, 32'hc);
      repeat (2) @(negedge pclk);
      chk({tx_wr_ptr, tx_rd_ptr}, 0);
      rd(TX_CTRL_OFS, 32'h8);
      fifo_req <= 4'hf;
      for (i = 0; i < 4; i++)
      begin
         for (n = 0; n < 20 && fifo_gnt === 4'h0; n++)
            @(negedge pclk);
         chk(fifo_gnt, 32'h1 << i);
         @(posedge pclk);
         fifo_req <= fifo_req & ~fifo_gnt;
         repeat (2) @(negedge pclk);
         chk(fifo_gnt, 32'h1 << i);
         for (n = 0; n < 20 && fifo_gnt !== 4'h0; n++)
            @(negedge pclk);
      end
      apb(1'b1, AUTO_PAUSE_OFS, 32'h0000_0810);
      rx_level <= 8'h20;
      repeat (5) @(negedge pclk);
      chk(pause_tx_req, 1'b0);
      @(posedge pclk) rx_level <= 8'h00;
      apb(1'b1, TX_CTRL_OFS, 32'h9);
      tx_fifo_wr <= 1'b1;
      @(posedge pclk) tx_fifo_wr <= 1'b0;
      apb(1'b1, PAUSE_CTRL_OFS, 32'h1234_0003);
      tx_busy <= 1'b1;
      pause_rx_valid <= 1'b1;
      pause_rx_time <= 16'h0002;
      @(posedge pclk);
      pause_rx_valid <= 1'b0;
      repeat (3) @(negedge pclk);
      chk(pause_active, 1'b0);
      @(posedge pclk);
      tx_busy <= 1'b0;
      repeat (IPG_T + 3) @(negedge pclk);
      chk({pause_active, tx_frame_start_ok}, 2);
      repeat (2 * SLOT_T + 2) @(negedge pclk);
      chk(pause_active, 1'b0);
      chk(tx_frame_start_ok, 1'b1);
      @(posedge pclk) rx_level <= 8'h10;
      for (n = 0; n < 20 && pause_tx_req !== 1'b1; n++)
         @(negedge pclk);
      chk(pause_tx_time, 16'h1234);
      @(posedge pclk) rx_level <= 8'h0c;
      repeat (4) @(negedge pclk);
      @(posedge pclk) rx_level <= 8'h20;
      repeat (5) @(negedge pclk);
      chk(pause_tx_req, 1'b0);
      @(posedge pclk) rx_level <= 8'h07;
      for (n = 0; n < 20 && pause_tx_req !== 1'b1; n++)
         @(negedge pclk);
      chk({pause_tx_req, pause_tx_time}, 32'h1_0000);
      apb(1'b1, AUTO_PAUSE_OFS, 32'h01ff_ff00);
      apb(1'b1, PAUSE_CTRL_OFS, 32'h0);
      frame_start();
      chk(jam_out, 1'b0);
      apb(1'b1, PAUSE_CTRL_OFS, 32'h1);
      frame_start();
      chk(jam_out, 1'b1);
      test_done();
   end
endmodule : etfc_top_tb
